// file: hdl/cpm_console_panel.sv
// console panel memory access: keys, switches, run control, core memory
// keys and switches arrive synchronous to clock; software uses AXI4-Lite
`timescale 1ns/1ps
`default_nettype none

module cpm_console_panel
  import cpm_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [WORD_W-1:0] panel_switch_word,
  input wire logic set_pointer_key,
  input wire logic store_key,
  input wire logic view_key,
  input wire logic start_key,
  input wire logic stop_key,
  input wire logic resume_key,
  input wire logic one_cycle_switch,
  input wire logic guard_switch,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic [WORD_W-1:0] memory_address,
  output logic [WORD_W-1:0] memory_buffer,
  output logic [WORD_W-1:0] program_counter,
  output logic [WORD_W-1:0] result_register,
  output logic carry_bit,
  output logic [2:0] opcode_holder,
  output logic run_lamp,
  output logic guard_halt_lamp,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic [WORD_W-1:0] core [MEM_WORDS];
  logic [N_KEYS-1:0] key_raw, key_s1, key_s2, key_s3, key_pulse;
  cpm_state_e state;
  cpm_op_e op;
  logic [5:0] cyc_cnt;
  logic start_pend, stop_pend, resume_pend, int_enable, fetch_state, panel_en;
  logic [EV_W-1:0] irq_status, irq_enable, events, irq_clear;
  logic key_done, run_done, guard_hit, start_go, resume_go, key_go;
  logic aw_held, w_held, write_do;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  assign key_raw = {resume_key, stop_key, start_key, view_key, store_key, set_pointer_key};
  assign key_done = (state == CPM_KEY) && (cyc_cnt == 6'h00);
  assign run_done = (state == CPM_RUN) && (cyc_cnt == 6'h00);
  assign guard_hit = guard_switch && (memory_address[11:7] == TOP_PAGE);
  // manual actions only when no memory cycle is in progress
  assign start_go = (state == CPM_IDLE) && start_pend;
  assign resume_go = (state == CPM_IDLE) && !start_pend && resume_pend;
  assign key_go = (state == CPM_IDLE) && !run_lamp && !start_pend && !resume_pend
    && panel_en && (key_pulse[K_SETPTR] || key_pulse[K_STORE] || key_pulse[K_VIEW]);
  assign write_do = aw_held && w_held && !s_axi_bvalid;
  assign irq_clear = (write_do && aw_addr == REG_IRQ_CLEAR) ? w_data[EV_W-1:0] : 3'h0;
  ////////////////////////////////////////////////////////////////////////
  // key synchronisers and edge detectors
  generate
    for (genvar k = 0; k < N_KEYS; k++) begin : g_key
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          key_s1[k] <= 1'b0;
          key_s2[k] <= 1'b0;
          key_s3[k] <= 1'b0;
          key_pulse[k] <= 1'b0;
        end else begin
          key_s1[k] <= key_raw[k];
          key_s2[k] <= key_s1[k];
          key_s3[k] <= key_s2[k];
          key_pulse[k] <= key_s2[k] && !key_s3[k];
        end
      end
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////
  // pending start, stop and resume requests
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      start_pend <= 1'b0;
      resume_pend <= 1'b0;
      stop_pend <= 1'b0;
    end else begin
      start_pend <= (start_pend && !start_go) || key_pulse[K_START];
      resume_pend <= (resume_pend && !resume_go && !start_go) || key_pulse[K_RESUME];
      // a stop is held until the running cycle ends
      stop_pend <= key_pulse[K_STOP] || stop_pend && !run_done && (state != CPM_IDLE || run_lamp);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // cycle sequencer
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= CPM_IDLE;
      cyc_cnt <= 6'h00;
      op <= OP_SET_POINTER;
    end else begin
      case (state)
        CPM_IDLE: begin
          if (key_go) begin
            state <= CPM_KEY;
            cyc_cnt <= CYC_LAST;
            op <= key_pulse[K_SETPTR] ? OP_SET_POINTER : key_pulse[K_STORE] ? OP_STORE : OP_VIEW;
          end else if (run_lamp && !start_go && !resume_go) begin
            state <= CPM_RUN;
            cyc_cnt <= CYC_LAST;
          end
        end
        CPM_KEY, CPM_RUN: begin
          if (cyc_cnt == 6'h00)
            state <= CPM_IDLE;
          else
            cyc_cnt <= cyc_cnt - 6'h01;
        end
        default: state <= CPM_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // run flip-flop, guard lamp, interrupt enable
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      run_lamp <= 1'b0;
      guard_halt_lamp <= 1'b0;
      int_enable <= 1'b0;
      fetch_state <= 1'b0;
    end else begin
      if (start_go) begin
        run_lamp <= 1'b1;
        int_enable <= 1'b0;
        fetch_state <= 1'b1;
        guard_halt_lamp <= 1'b0;
      end else if (resume_go) begin
        run_lamp <= 1'b1;
        guard_halt_lamp <= 1'b0;
      end else if (run_done && (stop_pend || one_cycle_switch)) begin
        run_lamp <= 1'b0;
      end
      if (key_done && op == OP_STORE && guard_hit) begin
        guard_halt_lamp <= 1'b1;
        run_lamp <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // processor registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      memory_address <= 12'h000;
      memory_buffer <= 12'h000;
      program_counter <= 12'h000;
      result_register <= 12'h000;
      carry_bit <= 1'b0;
      opcode_holder <= 3'h0;
    end else if (start_go) begin
      result_register <= 12'h000;
      carry_bit <= 1'b0;
      memory_buffer <= 12'h000;
      opcode_holder <= 3'h0;
      memory_address <= program_counter;
    end else if (key_done) begin
      // result_register and carry_bit are never touched here
      case (op)
        OP_SET_POINTER: begin
          memory_address <= panel_switch_word;
          program_counter <= panel_switch_word;
        end
        OP_STORE: begin
          if (!guard_hit) begin
            memory_buffer <= panel_switch_word;
            memory_address <= memory_address + 12'h001;
          end
        end
        OP_VIEW: begin
          memory_buffer <= core[memory_address];
          memory_address <= memory_address + 12'h001;
        end
        default: memory_buffer <= memory_buffer;
      endcase
    end else if (run_done) begin
      // minimal execution: each run cycle fetches the next word
      memory_address <= program_counter;
      memory_buffer <= core[program_counter];
      opcode_holder <= core[program_counter][11:9];
      program_counter <= program_counter + 12'h001;
    end
  end
  // core array has no reset, as real core keeps contents
  always_ff @(posedge clock) begin
    if (key_done && op == OP_STORE && !guard_hit)
      core[memory_address] <= panel_switch_word;
  end
  ////////////////////////////////////////////////////////////////////////
  // interrupt status, set wins over clear
  assign events = {run_done && (stop_pend || one_cycle_switch),
    key_done && op == OP_STORE && guard_hit, key_done};
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq_status <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clear) | events;
      irq <= |(irq_status & irq_enable);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (write_do) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          REG_CTRL, REG_STATUS, REG_ADDR, REG_BUF, REG_PC, REG_RESULT,
          REG_IRQ_STATUS, REG_IRQ_CLEAR, REG_IRQ_ENABLE: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_DECERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // narrow registers only take lane 0
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      panel_en <= CTRL_RESET;
      irq_enable <= IRQ_EN_RESET;
    end else if (write_do && s_axi_wstrb[0]) begin
      if (aw_addr == REG_CTRL)
        panel_en <= w_data[CTRL_PANEL_EN];
      if (aw_addr == REG_IRQ_ENABLE)
        irq_enable <= w_data[EV_W-1:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: s_axi_rdata <= {31'h0, panel_en};
        REG_STATUS: s_axi_rdata <= {27'h0, int_enable, fetch_state,
          state != CPM_IDLE, guard_halt_lamp, run_lamp};
        REG_ADDR: s_axi_rdata <= {20'h0, memory_address};
        REG_BUF: s_axi_rdata <= {20'h0, memory_buffer};
        REG_PC: s_axi_rdata <= {20'h0, program_counter};
        REG_RESULT: s_axi_rdata <= {19'h0, carry_bit, result_register};
        REG_IRQ_STATUS: s_axi_rdata <= {29'h0, irq_status};
        REG_IRQ_CLEAR: s_axi_rdata <= 32'h0000_0000;
        REG_IRQ_ENABLE: s_axi_rdata <= {29'h0, irq_enable};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_DECERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_view_end;
    key_done && op == OP_VIEW;
  endsequence
  sequence s_store_end;
    key_done && op == OP_STORE && !guard_hit;
  endsequence
  a_setptr_loads: assert property (
    key_done && op == OP_SET_POINTER |=> memory_address == $past(panel_switch_word)
      && program_counter == memory_address)
    else $error("set-pointer did not load address and counter");
  a_store_advance: assert property (
    s_store_end |=> memory_address == $past(memory_address) + 12'h001
      && memory_buffer == $past(panel_switch_word))
    else $error("store did not write buffer and advance address");
  a_view_advance: assert property (
    s_view_end |=> memory_address == $past(memory_address) + 12'h001)
    else $error("view did not advance address");
  a_key_keeps_result: assert property (
    state == CPM_KEY |=> $stable(result_register) && $stable(carry_bit))
    else $error("panel key changed result register");
  a_start_clears: assert property (
    start_go |=> run_lamp && result_register == 12'h000 && !int_enable
      && memory_address == $past(program_counter))
    else $error("start did not clear and run");
  a_stop_at_end: assert property (
    run_done && stop_pend |=> !run_lamp && state == CPM_IDLE)
    else $error("stop did not halt at cycle end");
  a_one_cycle: assert property (
    resume_go && one_cycle_switch |-> ##41 run_done ##1 !run_lamp && state == CPM_IDLE)
    else $error("one-cycle step ran more than one cycle");
  a_guard_halt: assert property (
    key_done && op == OP_STORE && guard_hit |=> guard_halt_lamp && !run_lamp
      && $stable(memory_address))
    else $error("guarded write not blocked");
  a_key_halted_only: assert property (
    state == CPM_IDLE && run_lamp |=> state != CPM_KEY)
    else $error("panel key acted while running");
  a_key_single: assert property (
    key_pulse[K_STORE] |=> !key_pulse[K_STORE])
    else $error("key press gave more than one pulse");
  a_key_one_cycle: assert property (
    key_go |=> state == CPM_KEY && cyc_cnt == CYC_LAST ##39 key_done ##1 state == CPM_IDLE)
    else $error("key action not one memory cycle");
endmodule // cpm_console_panel

`default_nettype wire

// file: hdl/cpm_pkg.sv
// console panel memory access: shared constants, register map and types
// assumes a 25 MHz processor clock and a 12-bit, 4096-word core memory
package cpm_pkg;

  ////////////////////////////////////////////////////////////////////////
  // word and memory geometry
  localparam int WORD_W = 12;
  localparam int MEM_WORDS = 4096;
  localparam logic [4:0] TOP_PAGE = 5'h1F;

  ////////////////////////////////////////////////////////////////////////
  // timing: one core memory cycle
  localparam int CLK_PERIOD_NS = 40;
  localparam int MEM_CYCLE_NS = 1600;
  localparam int MEM_CYCLE_CLKS = (MEM_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] CYC_LAST = 6'(MEM_CYCLE_CLKS - 1);

  ////////////////////////////////////////////////////////////////////////
  // register map, byte addresses on the AXI4-Lite port
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADDR = 8'h08;
  localparam logic [7:0] REG_BUF = 8'h0C;
  localparam logic [7:0] REG_PC = 8'h10;
  localparam logic [7:0] REG_RESULT = 8'h14;
  localparam logic [7:0] REG_IRQ_STATUS = 8'h18;
  localparam logic [7:0] REG_IRQ_CLEAR = 8'h1C;
  localparam logic [7:0] REG_IRQ_ENABLE = 8'h20;

  // field positions
  localparam int CTRL_PANEL_EN = 0;
  localparam int ST_RUN = 0;
  localparam int ST_GUARD = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_FETCH = 3;
  localparam int ST_INT_EN = 4;
  localparam int EV_KEY_DONE = 0;
  localparam int EV_GUARD = 1;
  localparam int EV_STOPPED = 2;
  localparam int EV_W = 3;

  // reset values
  localparam logic CTRL_RESET = 1'b1;
  localparam logic [2:0] IRQ_EN_RESET = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    CPM_IDLE = 2'b00,
    CPM_KEY = 2'b01,
    CPM_RUN = 2'b10
  } cpm_state_e;

  typedef enum logic [1:0] {
    OP_SET_POINTER = 2'h0,
    OP_STORE = 2'h1,
    OP_VIEW = 2'h2
  } cpm_op_e;

  // key vector positions
  localparam int K_SETPTR = 0;
  localparam int K_STORE = 1;
  localparam int K_VIEW = 2;
  localparam int K_START = 3;
  localparam int K_STOP = 4;
  localparam int K_RESUME = 5;
  localparam int N_KEYS = 6;

endpackage

// file: testbench/cpm_operator_model.sv
// operator at the console: one key press at a time, switch word held
// assumes keys are sampled on clock; done rises well after the key cycle
`timescale 1ns/1ps
`default_nettype none
module cpm_operator_model
  import cpm_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic go,
  input wire logic [2:0] key_sel,
  input wire logic [WORD_W-1:0] word,
  output logic [WORD_W-1:0] panel_switch_word,
  output logic [N_KEYS-1:0] keys,
  output logic done
);
  logic [6:0] cnt;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      keys <= '0;
      cnt <= 7'h00;
      done <= 1'b0;
      panel_switch_word <= '0;
    end else if (go) begin
      panel_switch_word <= word;
      keys <= N_KEYS'(1) << key_sel;
      cnt <= 7'h00;
      done <= 1'b0;
    end else if (!done) begin
      cnt <= cnt + 7'h01;
      // short press, then low long before the next one
      if (cnt == 7'h02) keys <= '0;
      // wait out the 40 clock memory cycle with margin
      if (cnt == 7'h3C) done <= 1'b1;
    end
  end
endmodule // cpm_operator_model
`default_nettype wire

// file: testbench/tb_console_panel_memory_access.sv
// self-checking bench for the console panel block
// assumes the operator model drives keys and the switch word; bench sets the guard and one-cycle switches and is bus master
`timescale 1ns/1ps
`default_nettype none
module tb_console_panel_memory_access;
  import cpm_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic go = 1'b0, one_cycle_switch = 1'b0, guard_switch = 1'b0;
  logic [2:0] key_sel = 3'h0;
  logic [11:0] op_word = 12'h000;
  logic [11:0] sw, ma, mb, pc, res;
  logic [N_KEYS-1:0] keys;
  logic done, carry, run, guard, irq;
  logic [2:0] opc;
  logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd, got;
  logic awr, wr, bv, arr, rv;
  logic [1:0] br, rr, resp;
  int fails = 0;
  int samples_checked = 0;

  always #20 clock = ~clock;

  cpm_operator_model cpm_operator_model_inst (.clock(clock), .nrst(nrst), .go(go),
    .key_sel(key_sel), .word(op_word), .panel_switch_word(sw), .keys(keys), .done(done));

  cpm_console_panel cpm_console_panel_inst (.clock(clock), .nrst(nrst),
    .panel_switch_word(sw), .set_pointer_key(keys[K_SETPTR]), .store_key(keys[K_STORE]),
    .view_key(keys[K_VIEW]), .start_key(keys[K_START]), .stop_key(keys[K_STOP]),
    .resume_key(keys[K_RESUME]), .one_cycle_switch(one_cycle_switch),
    .guard_switch(guard_switch), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .s_axi_rdata(rd), .s_axi_rresp(rr), .memory_address(ma),
    .memory_buffer(mb), .program_counter(pc), .result_register(res), .carry_bit(carry),
    .opcode_holder(opc), .run_lamp(run), .guard_halt_lamp(guard), .irq(irq));

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (fails == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic miss(input string m);
    fails++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e) miss(m);
  endtask

  task automatic chk_bit(input logic g, input logic e, input string m);
    samples_checked++;
    if (g !== e) miss(m);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // bus tasks start just after a rising edge and end on one
  // waits end only by the answer; the watchdog covers a hang
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    do begin
      @(posedge clock);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (bv !== 1'b1);
    resp = br;
    bre <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do begin
      @(posedge clock);
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    got = rd;
    resp = rr;
    rre <= 1'b0;
  endtask

  task automatic press(input int k, input logic [11:0] w);
    go <= 1'b1;
    key_sel <= 3'(k);
    op_word <= w;
    @(posedge clock);
    go <= 1'b0;
    do begin
      @(posedge clock);
    end while (done !== 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk_word(32'(ma), 32'h0, "address after reset");
    chk_bit(run, 1'b0, "run after reset");
    axi_read(REG_CTRL);
    chk_word(got, 32'h1, "ctrl reset");
    axi_read(REG_IRQ_ENABLE);
    chk_word(got, 32'h0, "irq enable reset");
    axi_read(8'h40);
    chk_word({got[29:0], resp}, {30'h0, RESP_DECERR}, "unmapped read");
    axi_write(8'h40, 32'h1);
    chk_word(32'(resp), 32'(RESP_DECERR), "unmapped write");
  endtask

  task automatic t_load;
    press(K_SETPTR, 12'h5A5);
    chk_word(32'(ma), 32'h5A5, "address load");
    chk_word(32'(pc), 32'h5A5, "counter load");
  endtask

  task automatic t_store;
    press(K_SETPTR, 12'h010);
    press(K_STORE, 12'h123);
    press(K_STORE, 12'h456);
    chk_word(32'(mb), 32'h456, "stored buffer");
    chk_word(32'(ma), 32'h012, "store advance");
    chk_word(32'(res), 32'h0, "result kept");
    axi_read(REG_BUF);
    chk_word(got, 32'h456, "buffer register");
  endtask

  task automatic t_view;
    press(K_SETPTR, 12'h010);
    press(K_VIEW, 12'hFFF);
    chk_word(32'(mb), 32'h123, "view first");
    chk_word(32'(ma), 32'h011, "view advance");
    press(K_VIEW, 12'h000);
    chk_word({20'h0, mb}, 32'h456, "view second");
    chk_word(32'(ma), 32'h012, "view advance again");
    axi_write(REG_CTRL, 32'h0);
    press(K_VIEW, 12'h000);
    chk_word(32'(ma), 32'h012, "panel locked out");
    axi_write(REG_CTRL, 32'h1);
  endtask

  task automatic t_irq;
    axi_write(REG_IRQ_ENABLE, 32'h1);
    repeat (2) @(posedge clock);
    chk_bit(irq, 1'b1, "irq raised");
    axi_read(REG_IRQ_STATUS);
    chk_bit(got[EV_KEY_DONE], 1'b1, "key done event");
    axi_write(REG_IRQ_CLEAR, 32'h7);
    repeat (2) @(posedge clock);
    chk_bit(irq, 1'b0, "irq cleared");
    axi_write(REG_IRQ_ENABLE, 32'h0);
  endtask

  task automatic t_guard;
    guard_switch <= 1'b1;
    press(K_SETPTR, 12'hF7F);
    press(K_STORE, 12'h0AA);
    chk_word(32'(ma), 32'hF80, "below top page");
    chk_bit(guard, 1'b0, "no guard below page");
    press(K_STORE, 12'h0BB);
    chk_word(32'(ma), 32'hF80, "guarded no advance");
    chk_bit(guard, 1'b1, "guard lamp");
    chk_bit(run, 1'b0, "guard halted");
    axi_read(REG_IRQ_STATUS);
    chk_bit(got[EV_GUARD], 1'b1, "guard event");
    guard_switch <= 1'b0;
  endtask

  task automatic t_run;
    press(K_SETPTR, 12'h010);
    press(K_START, 12'h010);
    chk_bit(run, 1'b1, "start runs");
    chk_word({carry, res}, 32'h0, "start clears result");
    axi_read(REG_STATUS);
    chk_bit(got[ST_FETCH], 1'b1, "fetch state set");
    chk_bit(got[ST_INT_EN], 1'b0, "interrupts off");
    chk_bit(guard, 1'b0, "restart clears guard");
    press(K_SETPTR, 12'hABC);
    chk_bit(pc == 12'hABC, 1'b0, "key ignored while running");
    press(K_STOP, 12'h000);
    chk_bit(run, 1'b0, "stop halts");
    axi_read(REG_IRQ_STATUS);
    chk_bit(got[EV_STOPPED], 1'b1, "stop event");
  endtask

  task automatic t_step;
    one_cycle_switch <= 1'b1;
    press(K_SETPTR, 12'h011);
    press(K_RESUME, 12'h000);
    chk_bit(run, 1'b0, "one cycle halt");
    chk_word(32'(pc), 32'h012, "resume from counter");
    chk_word({mb, 1'b0, opc}, {12'h456, 4'h2}, "fetched word");
    press(K_RESUME, 12'h000);
    chk_word(32'(pc), 32'h013, "one more cycle");
    one_cycle_switch <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    t_reset();
    t_load();
    t_store();
    t_view();
    t_irq();
    t_guard();
    t_run();
    t_step();
    final_report();
  end

  // about twenty presses of some 65 cycles each, plus bus traffic
  initial begin
    repeat (5000) @(posedge clock);
    miss("watchdog");
    final_report();
  end
endmodule // tb_console_panel_memory_access
`default_nettype wire
